// >>> rtl/odc_port.sv
// Purpose: Serial command decoder and register bank for an octal 8-bit DAC.
// Assumes: Serial clock is far slower than sys_clk; pins pass two flops.
// Notes:   Only 101, 110 and 111 execute here; other codes act as no-ops.
module odc_port
  import odc_pkg::*;
(
  input  wire logic                                sys_clk,
  input  wire logic                                rstn,
  input  wire logic                                clk_en,
  input  wire logic                                cs_n,
  input  wire logic                                sclk,
  input  wire logic                                din,
  input  wire logic                                load_all_n,
  input  wire logic                                phase_mode1,
  output logic                                     dout,
  output logic                                     dout_oe,
  output logic                                     shutdown,
  output logic [odc_pkg::CHANNELS*odc_pkg::DATA_BITS-1:0] dac_code_value,
  output logic [odc_pkg::CHANNELS*odc_pkg::DATA_BITS-1:0] input_code
);
  import odc_pkg::*;

  logic                 cs_s, sclk_s, din_s, load_all_n_s;
  logic                 sclk_prev_q, cs_prev_q;
  logic                 sclk_rise, sclk_fall, cs_rise;
  logic [WORD_BITS-1:0] shift_q;
  logic [DATA_BITS-1:0] in_reg_q  [CHANNELS];
  logic [DATA_BITS-1:0] dac_reg_q [CHANNELS];
  logic                 shutdown_q;
  logic [2:0]           channel_select_field;
  logic [2:0]           command_code_field;
  logic [DATA_BITS-1:0] data_byte_field;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  odc_sync #(.RESET_VAL(1'b1)) u_cs
  (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
   .pin_in(cs_n), .pin_sync(cs_s));
  odc_sync #(.RESET_VAL(1'b0)) u_sclk
  (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
   .pin_in(sclk), .pin_sync(sclk_s));
  odc_sync #(.RESET_VAL(1'b0)) u_din
  (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
   .pin_in(din), .pin_sync(din_s));
  odc_sync #(.RESET_VAL(1'b1)) u_load_all
  (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
   .pin_in(load_all_n), .pin_sync(load_all_n_s));

  // ----------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end
    else if (clk_en)
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_s;
    end
  end

  // Clock edges count only inside a frame
  assign sclk_rise = clk_en && sclk_s && !sclk_prev_q && !cs_s;
  assign sclk_fall = clk_en && !sclk_s && sclk_prev_q && !cs_s;
  assign cs_rise   = clk_en && cs_s && !cs_prev_q;

  assign channel_select_field = odc_addr(shift_q);
  assign command_code_field   = odc_cmd(shift_q);
  assign data_byte_field      = shift_q[DATA_LSB +: DATA_BITS];

  // ----------------------------------------
  // Shift register, MSB first
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      shift_q <= SHIFT_RESET;
    else if (sclk_rise)
      shift_q <= {shift_q[WORD_BITS-2:0], din_s};
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // Mode 0 updates on the fall after the bit left, adding half a cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      dout <= 1'b0;
    else if (!phase_mode1 && sclk_fall)
      dout <= shift_q[WORD_BITS-1];
    else if (phase_mode1 && sclk_rise)
      dout <= shift_q[WORD_BITS-2];
  end
  assign dout_oe = 1'b1; // Never floats

  // ----------------------------------------
  // Input registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < CHANNELS; i++)
        in_reg_q[i] <= CODE_RESET;
    end
    else if (cs_rise)
    begin
      case (odc_cmd_t'(command_code_field))
        load_input_cmd, load_both_cmd:
          in_reg_q[channel_select_field] <= data_byte_field;
        default: ; // No-operation and others leave registers
      endcase
    end
  end

  // ----------------------------------------
  // DAC registers; transparent while load_all_n low
  // ----------------------------------------
  // Transparency is emulated by copying every cycle, one cycle late
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < CHANNELS; i++)
        dac_reg_q[i] <= CODE_RESET;
    end
    else if (clk_en)
    begin
      if (!load_all_n_s)
      begin
        for (int i = 0; i < CHANNELS; i++)
          dac_reg_q[i] <= in_reg_q[i];
      end
      else if (cs_rise)
      begin
        case (odc_cmd_t'(command_code_field))
          load_both_cmd:
            dac_reg_q[channel_select_field] <= data_byte_field;
          soft_load_cmd:
            for (int i = 0; i < CHANNELS; i++)
              dac_reg_q[i] <= in_reg_q[i];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Shutdown state
  // ----------------------------------------
  // No entry command is decoded anywhere; only the release is decoded
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      shutdown_q <= 1'b0;
    else if (cs_rise && command_code_field == load_both_cmd)
      shutdown_q <= 1'b0;
  end
  assign shutdown = shutdown_q;

  // Straight binary codes out, channel 0 in low byte
  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      dac_code_value[i*DATA_BITS +: DATA_BITS] = dac_reg_q[i];
      input_code[i*DATA_BITS +: DATA_BITS]     = in_reg_q[i];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_load_input_only: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    cs_rise && load_all_n_s && command_code_field == load_input_cmd
    |=> in_reg_q[$past(channel_select_field)] == $past(data_byte_field)
        && dac_code_value == $past(dac_code_value))
    else $error("load input changed wrong register");
  a_load_both_regs: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    cs_rise && load_all_n_s && command_code_field == load_both_cmd
    |=> dac_reg_q[$past(channel_select_field)] == $past(data_byte_field)
        && in_reg_q[$past(channel_select_field)] == $past(data_byte_field))
    else $error("load both failed");
  a_wake_release: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    cs_rise && command_code_field == load_both_cmd |=> !shutdown)
    else $error("shutdown not released");
  a_soft_load_all: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    cs_rise && command_code_field == soft_load_cmd
    |=> dac_code_value == $past(input_code))
    else $error("soft load failed");
  a_transparent_dac: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    clk_en && !load_all_n_s |=> dac_code_value == $past(input_code))
    else $error("dac not transparent");
  a_dout_hold_cs: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    cs_s && $past(cs_s) |-> $stable(dout))
    else $error("dout moved with cs high");
  a_mode0_edge: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    !phase_mode1 && !sclk_fall |=> $stable(dout))
    else $error("dout moved off falling edge");
  a_nop_no_change: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    cs_rise && load_all_n_s && command_code_field == no_operation_cmd
    |=> $stable(input_code) && $stable(dac_code_value))
    else $error("no-op changed registers");
  a_no_shift_idle: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    cs_s |=> $stable(shift_q))
    else $error("shifted with cs high");

  c_load_input: cover property (@(posedge sys_clk)
    cs_rise && command_code_field == load_input_cmd);
  c_load_both: cover property (@(posedge sys_clk)
    cs_rise && command_code_field == load_both_cmd);
  c_soft_load: cover property (@(posedge sys_clk)
    cs_rise && command_code_field == soft_load_cmd);
  c_transparent: cover property (@(posedge sys_clk) !load_all_n_s && cs_rise);
  c_mode1_out: cover property (@(posedge sys_clk)
    phase_mode1 && sclk_rise);
endmodule : odc_port

// >>> rtl/odc_pkg.sv
// Purpose: Constants and types for the octal DAC serial command port.
// Assumes: Serial pins are sampled by sys_clk (40 MHz), link clock far slower.
// Notes:   Command word is 16 bits, MSB first.
package odc_pkg;
  localparam int WORD_BITS    = 16;
  localparam int CHANNELS     = 8;
  localparam int DATA_BITS    = 8;
  localparam int DATA_LSB     = 0;
  localparam int CMD_LSB      = 8;
  localparam int ADDR_LSB     = 11;
  localparam logic [DATA_BITS-1:0] CODE_RESET = 8'h00;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;

  typedef enum logic [2:0]
  {
    no_operation_cmd = 3'h0,
    clear_cmd        = 3'h1,
    shutdown_cmd     = 3'h2,
    phase_cmd        = 3'h3,
    load_same_cmd    = 3'h4,
    load_input_cmd   = 3'h5,
    load_both_cmd    = 3'h6,
    soft_load_cmd    = 3'h7
  } odc_cmd_t;

  // Field extraction, used by decode and by checks
  function automatic logic [2:0] odc_addr(input logic [WORD_BITS-1:0] w);
    odc_addr = w[ADDR_LSB +: 3];
  endfunction : odc_addr

  function automatic logic [2:0] odc_cmd(input logic [WORD_BITS-1:0] w);
    odc_cmd = w[CMD_LSB +: 3];
  endfunction : odc_cmd
endpackage : odc_pkg

// >>> rtl/odc_sync.sv
// Purpose: Two flip-flop synchroniser for one pin.
// Assumes: Pin is asynchronous to sys_clk.
// Notes:   First stage is read only by the second stage.
module odc_sync
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      pin_sync
);
  import odc_pkg::*;
  logic meta_q;

  // ----------------------------------------
  // Two stages
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q   <= RESET_VAL;
      pin_sync <= RESET_VAL;
    end
    else if (clk_en)
    begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule : odc_sync

// >>> test/odc_host.sv
// Purpose: Serial master model driving the command port pins.
// Assumes: Clock idles low, data set while clock low, MSB first.
// Notes:   Samples serial out where each phase mode has settled.
module odc_host
(
  input  wire logic sys_clk,
  input  wire logic dout,
  input  wire logic mode1,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle pins: deselected, clock low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // Half a serial clock period is four system clocks
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask : half

  // One frame of n bits; rx keeps the serial out seen per bit
  task automatic frame(input int n, input logic [31:0] w,
                       output logic [31:0] rx);
    logic s1;
    logic s0;
    rx   = 32'h0000_0000;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = w[i];
      half();
      s1   = dout;
      sclk = 1'b1;
      half();
      s0   = dout;
      rx   = {rx[30:0], mode1 ? s1 : s0};
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    din  = ~din; // Released line shows no stale value
    half();
  endtask : frame

  // Clock pulses with chip select high, which must be ignored
  task automatic stray(input int n);
    repeat (n)
    begin
      sclk = 1'b1;
      half();
      sclk = 1'b0;
      half();
    end
  endtask : stray
endmodule : odc_host

// >>> test/odc_port_tb.sv
// Purpose: Self-checking bench for the octal DAC command port.
// Assumes: Host model drives the serial pins at 200 ns per bit.
// Notes:   Driver notes expectations; a watcher compares them.
module odc_port_tb
  import odc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed
  {
    logic [63:0] inp;
    logic [63:0] dac;
  } odc_note_t;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        load_all_n = 1'b1;
  logic        phase_mode1 = 1'b0;
  logic        cs_n, sclk, din, dout, dout_oe, shutdown;
  logic [63:0] dac_code_value, input_code, exp_in, exp_dac;
  logic [31:0] rx;
  logic        held;
  logic [15:0] w;
  int          err_count = 0;
  int          n_compared = 0;
  odc_note_t   notes[$];
  event        chk_ev;

  always #12.5 sys_clk = ~sys_clk;

  odc_host u_odc_host (.sys_clk(sys_clk), .dout(dout), .mode1(phase_mode1),
    .cs_n(cs_n), .sclk(sclk), .din(din));

  odc_port u_odc_port (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1),
    .cs_n(cs_n), .sclk(sclk), .din(din), .load_all_n(load_all_n),
    .phase_mode1(phase_mode1), .dout(dout), .dout_oe(dout_oe),
    .shutdown(shutdown), .dac_code_value(dac_code_value),
    .input_code(input_code));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // Settle time covers two sync flops, edge detect and update
  task automatic note();
    repeat (8) @(negedge sys_clk);
    notes.push_back('{exp_in, exp_dac});
    -> chk_ev;
  endtask : note

  // Send one word and work out what the registers become
  task automatic send(input logic [2:0] a, input logic [2:0] c,
                      input logic [7:0] d);
    u_odc_host.frame(16, {16'h0000, 2'b00, a, c, d}, rx);
    if (c == load_input_cmd || c == load_both_cmd)
      exp_in[a*8 +: 8] = d;
    if (c == load_both_cmd)
      exp_dac[a*8 +: 8] = d;
    if (c == soft_load_cmd || !load_all_n)
      exp_dac = exp_in;
    note();
  endtask : send

  // Watcher takes the oldest note when a result is due
  always @(chk_ev)
  begin
    odc_note_t n;
    n = notes.pop_front();
    check(input_code, n.inp);
    check(dac_code_value, n.dac);
  end

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #200us;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h2dcf));
    exp_in  = 64'h0;
    exp_dac = 64'h0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({dout_oe, dout, shutdown}, 3'h4);
    note();
    $display("test reset done");
    for (int ch = 0; ch < 8; ch++)
      send(ch[2:0], load_input_cmd, 8'($urandom));
    send(3'h0, soft_load_cmd, 8'($urandom));
    send(3'h2, load_both_cmd, 8'($urandom));
    check(shutdown, 1'b0);
    send(3'h7, no_operation_cmd, 8'($urandom));
    $display("test commands done");
    load_all_n = 1'b0;
    send(3'h5, load_input_cmd, 8'($urandom));
    load_all_n = 1'b1;
    $display("test hardware load done");
    for (int m = 0; m < 2; m++)
    begin
      phase_mode1 = m[0];
      w = 16'($urandom);
      u_odc_host.frame(32, {w, 16'h0000}, rx);
      check(rx[15:0], w);
      held = dout;
      u_odc_host.stray(3);
      check(dout, held);
      note();
    end
    $display("test serial out done");
    report_and_stop();
  end
endmodule : odc_port_tb
